// ==== verilog/sbwd_regs.svh ====
// Constants for the serial bus watchdog: codes, reset values, timing.
// Assumes inclusion by the package and the design file only.
`ifndef SBWD_REGS_SVH
`define SBWD_REGS_SVH
`define SBWD_DIS_W 4
`define SBWD_DIS_CODE 4'hB
`define SBWD_DIS_RST 4'hB
`define SBWD_CLK_HZ 250000000
`define SBWD_BASE_HZ 7400000
`define SBWD_TIMEOUT_S 2
`define SBWD_BASE_DIV ((`SBWD_CLK_HZ + `SBWD_BASE_HZ - 1) / `SBWD_BASE_HZ)
`define SBWD_TIMEOUT_TICKS (`SBWD_TIMEOUT_S * `SBWD_BASE_HZ)
`endif

// ==== verilog/sbwd_pkg.sv ====
// Types for the serial bus watchdog.
// Assumes the constants header is on the include path.
`include "sbwd_regs.svh"
package sbwd_pkg;
	typedef struct packed {
		logic wr;
		logic [`SBWD_DIS_W-1:0] code;
	} sbwd_dis_wr_t;
	typedef enum logic [1:0] {
		SBWD_OFF = 2'h1,
		SBWD_RUN = 2'h2
	} sbwd_state_t;
endpackage

// ==== verilog/sbwd_top.sv ====
// Serial management bus watchdog: timeout on missing clock edges.
// Assumes serial clock sampled synchronously; register writes arrive as strobes.
// Functional notes
// R1: Watch serial clock edges while enabled
// R2: Timeout resets serial logic, shuts active ports
// R3: Two seconds idle latches ports off, flags
// R4: Flag clears only by reset or zero write
// R5: Four-bit disable field, code 1011b disables
// R6: Disable field preset to 1011b at reset
// R7: Time base of about 7.4 MHz divided from the 250 MHz clock
// R8: Target only, never stretches clock line
// R9: Each clock edge restarts count from zero
`timescale 1ns/1ps
`include "sbwd_regs.svh"
module sbwd_top
	import sbwd_pkg::*;
#(
	parameter int unsigned TIMEOUT_TICKS = `SBWD_TIMEOUT_TICKS,
	parameter int unsigned BASE_DIV = `SBWD_BASE_DIV
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_scl,
	input wire sbwd_dis_wr_t i_dis_wr,
	input wire logic i_flag_wr,
	input wire logic i_flag_wdata,
	output logic o_bus_timeout_flag,
	output logic [`SBWD_DIS_W-1:0] o_dis_code,
	output logic o_serial_reset,
	output logic o_ports_off,
	output logic o_scl_oe
);
	logic rst_s1_q;
	logic rst_s2_q;
	logic scl_q;
	logic [7:0] div_q;
	logic base_tick;
	logic [31:0] cnt_q;
	logic edge_seen;
	logic expire;
	logic [`SBWD_DIS_W-1:0] dis_q;
	sbwd_state_t state_q;

	function automatic logic is_disabled(input logic [`SBWD_DIS_W-1:0] c);
		return c == `SBWD_DIS_CODE;
	endfunction

	// Reset released through two flops; assertion stays asynchronous
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire rst_n = rst_s2_q;

	// Sampled line; preset high so reset shows no false edge
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
		end else if (i_ce) begin
			scl_q <= i_scl;
		end
	end
	assign edge_seen = scl_q ^ i_scl; // [R1]

	// Field written whole; any code but 1011b arms the watchdog
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			dis_q <= `SBWD_DIS_RST; // [R6]
		end else if (i_ce && i_dis_wr.wr) begin
			dis_q <= i_dis_wr.code; // [R5]
		end
	end

	// Watchdog runs only while the field holds a code other than 1011b
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SBWD_OFF;
		end else if (i_ce) begin
			case (state_q)
				SBWD_OFF: begin
					if (!is_disabled(dis_q)) begin
						state_q <= SBWD_RUN;
					end
				end
				SBWD_RUN: begin
					if (is_disabled(dis_q)) begin
						state_q <= SBWD_OFF;
					end
				end
				default: state_q <= SBWD_OFF;
			endcase
		end
	end

	// Prescaler approximates the 7.4 MHz base tick from the fast clock
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 8'h00;
		end else if (i_ce) begin
			if (state_q != SBWD_RUN || edge_seen || base_tick) begin
				div_q <= 8'h00;
			end else begin
				div_q <= div_q + 8'h01;
			end
		end
	end
	assign base_tick = (32'(div_q) == BASE_DIV - 1); // [R7]

	// Edge in the expiry cycle wins: count restarts, no timeout
	assign expire = base_tick && !edge_seen &&
		(cnt_q == TIMEOUT_TICKS - 1); // [R9]

	// Count of base ticks since the last edge, enable or timeout
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
		end else if (i_ce) begin
			if (state_q != SBWD_RUN || edge_seen || expire) begin
				cnt_q <= 32'h0; // [R9]
			end else if (base_tick) begin
				cnt_q <= cnt_q + 32'h1;
			end
		end
	end

	// Serial reset is a one-cycle pulse; port shutdown is latched
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_serial_reset <= 1'b0;
			o_ports_off <= 1'b0;
		end else if (i_ce) begin
			o_serial_reset <= expire && state_q == SBWD_RUN; // [R2]
			if (expire && state_q == SBWD_RUN) begin
				o_ports_off <= 1'b1; // [R3]
			end else if (i_flag_wr && !i_flag_wdata) begin
				o_ports_off <= 1'b0;
			end
		end
	end

	// A timeout in the clearing cycle keeps the flag set
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_bus_timeout_flag <= 1'b0;
		end else if (i_ce) begin
			if (expire && state_q == SBWD_RUN) begin
				o_bus_timeout_flag <= 1'b1; // [R3]
			end else if (i_flag_wr && !i_flag_wdata) begin
				o_bus_timeout_flag <= 1'b0; // [R4]
			end
		end
	end

	// Clock line is never driven: target only, no stretching
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_dis_code <= `SBWD_DIS_RST;
			o_scl_oe <= 1'b0;
		end else if (i_ce) begin
			o_dis_code <= dis_q;
			o_scl_oe <= 1'b0; // [R8]
		end
	end

	a_flag_held: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_bus_timeout_flag && !(i_ce && i_flag_wr && !i_flag_wdata) |=> o_bus_timeout_flag)
		else $error("timeout flag dropped without clear"); // [R4]
	a_reset_preset: assert property (@(posedge i_clk) $rose(rst_n) |-> dis_q == 4'hB)
		else $error("disable field not preset"); // [R6]
	a_off_no_timeout: assert property (@(posedge i_clk) disable iff (!rst_n)
		is_disabled(dis_q) && state_q == SBWD_OFF |=> !o_serial_reset)
		else $error("timeout while disabled"); // [R5]
	a_edge_restart: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_ce && edge_seen |=> cnt_q == 32'h0)
		else $error("edge did not restart count"); // [R9]
	a_timeout_both: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_serial_reset |-> o_ports_off && o_bus_timeout_flag)
		else $error("timeout effects not together"); // [R2]
	a_expire_flags: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_ce && expire && state_q == SBWD_RUN |=> o_bus_timeout_flag && o_ports_off)
		else $error("expiry did not set flag"); // [R3]
	a_div_bound: assert property (@(posedge i_clk) disable iff (!rst_n)
		32'(div_q) < BASE_DIV)
		else $error("prescaler overran"); // [R7]
	a_no_stretch: assert property (@(posedge i_clk) disable iff (!rst_n) !o_scl_oe)
		else $error("clock line driven"); // [R8]
	a_run_watch: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_ce && state_q == SBWD_RUN && !is_disabled(dis_q) && edge_seen |=> !o_serial_reset)
		else $error("timeout despite edge"); // [R1]

	// Timeout: expiry cycle, then all effects together for one cycle
	sequence s_expire_cycle;
		i_ce && expire && state_q == SBWD_RUN;
	endsequence

	sequence s_timeout_seen;
		o_serial_reset && o_bus_timeout_flag && o_ports_off;
	endsequence

	a_timeout_pulse: assert property (@(posedge i_clk) disable iff (!rst_n) // [R2]
		s_expire_cycle |=> s_timeout_seen ##1 !o_serial_reset)
		else $error("timeout pulse wrong");
	a_flag_clear: assert property (@(posedge i_clk) disable iff (!rst_n) // [R4]
		i_ce && i_flag_wr && !i_flag_wdata && !expire |=> !o_bus_timeout_flag)
		else $error("zero write did not clear flag");
	a_dis_follow: assert property (@(posedge i_clk) disable iff (!rst_n) // [R5]
		i_ce && i_dis_wr.wr |=> ##1 o_dis_code == $past(i_dis_wr.code, 2))
		else $error("disable field not shown");
	a_count_bound: assert property (@(posedge i_clk) disable iff (!rst_n) // [R3]
		cnt_q < TIMEOUT_TICKS)
		else $error("timeout count overran");
	a_run_enable: assert property (@(posedge i_clk) disable iff (!rst_n) // [R5]
		i_ce && !is_disabled(dis_q) |=> state_q == SBWD_RUN)
		else $error("watchdog not armed");
endmodule

// ==== bench/sbwd_host_model.sv ====
// Bus master stand-in: drives the serial clock line seen by the watchdog.
// Assumes a pulled-up line that idles high between transfers.
`timescale 1ns/1ps
module sbwd_host_model (
	input wire logic i_clk,
	input wire logic i_run,
	output logic o_scl
);
	logic [1:0] div_q = 2'h0;
	initial o_scl = 1'b1;
	// Toggle every second cycle while a transfer runs; park high otherwise
	always @(negedge i_clk) begin
		div_q <= div_q + 2'h1;
		if (!i_run)
			o_scl <= 1'b1;
		else if (div_q[0])
			o_scl <= ~o_scl;
	end
endmodule

// ==== bench/serial_bus_watchdog_bench.sv ====
// Self-checking bench for the serial bus watchdog.
// Assumes a shortened timeout of 4 ticks of 2 cycles each.
`timescale 1ns/1ps
module serial_bus_watchdog_bench;
	import sbwd_pkg::*;
	logic clk = 0, rst_n = 0, run = 0, fwr = 0, fd = 0;
	sbwd_dis_wr_t dw = '0;
	logic scl, flag, sr, poff, oe;
	logic [3:0] code, rc;
	int n_mismatch = 0, cmp_count = 0, seed = 32'h241c, pulses = 0;
	always #2 clk = ~clk;
	sbwd_host_model u_sbwd_host_model(.i_clk(clk), .i_run(run), .o_scl(scl));
	sbwd_top #(.TIMEOUT_TICKS(4), .BASE_DIV(2)) u_sbwd_top(.i_clk(clk), .i_reset_n(rst_n),
		.i_ce(1'b1), .i_scl(scl), .i_dis_wr(dw), .i_flag_wr(fwr), .i_flag_wdata(fd),
		.o_bus_timeout_flag(flag), .o_dis_code(code), .o_serial_reset(sr),
		.o_ports_off(poff), .o_scl_oe(oe));
	always @(posedge clk) if (sr === 1'b1) pulses <= pulses + 1;
	// Reference model: 8 quiet enabled cycles per timeout
	logic en_m = 0, scl_m = 1, sr_m = 0, flag_m = 0;
	logic [3:0] dis_m = 4'hB;
	int idle_m = 0;
	wire tick_m = en_m && scl === scl_m && idle_m == 7;
	always @(posedge clk) begin
		if (rst_n) begin
			chk(4'(sr), 4'(sr_m));
			chk(4'(flag), 4'(flag_m));
		end
		if (dw.wr) dis_m <= dw.code;
		en_m <= dis_m != 4'hB;
		idle_m <= (!en_m || scl !== scl_m || tick_m) ? 0 : idle_m + 1;
		sr_m <= tick_m;
		if (tick_m) flag_m <= 1'b1;
		else if (fwr && !fd) flag_m <= 1'b0;
		scl_m <= scl;
	end
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr_dis(input logic [3:0] c);
		@(negedge clk);
		dw = '{wr: 1'b1, code: c};
		@(negedge clk);
		dw.wr = 1'b0;
		idle(3);
	endtask
	task automatic wr_flag(input logic d);
		@(negedge clk);
		fwr = 1'b1;
		fd = d;
		@(negedge clk);
		fwr = 1'b0;
		idle(1);
	endtask
	task stop_test;
		$display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Whole run needs well under 1000 cycles
	initial begin
		#20000;
		n_mismatch++;
		stop_test;
	end
	initial begin
		idle(5);
		rst_n = 1'b1;
		idle(4);
		chk(code, 4'hB);
		chk({1'b0, flag, poff, oe}, 4'h0);
		idle(20);
		chk({2'h0, flag, poff}, 4'h0);
		$display("test reset and disabled done");
		rc = 4'($random(seed));
		if (rc == 4'hB)
			rc = 4'h0;
		wr_dis(rc);
		chk(code, rc);
		run = 1'b1;
		idle(40);
		chk({2'h0, flag, poff}, 4'h0);
		run = 1'b0;
		idle(20);
		chk({2'h0, flag, poff}, 4'h3);
		chk(4'(pulses > 0), 4'h1);
		chk(4'(oe), 4'h0);
		$display("test timeout done");
		run = 1'b1;
		wr_flag(1'b1);
		chk(4'(flag), 4'h1);
		wr_flag(1'b0);
		chk({2'h0, flag, poff}, 4'h0);
		$display("test flag clear done");
		wr_dis(4'hB);
		run = 1'b0;
		idle(30);
		chk({2'h0, flag, poff}, 4'h0);
		chk(code, 4'hB);
		$display("test disable again done");
		stop_test;
	end
endmodule
